// *** rtl/diag_monitor_defs.svh ***
// Register offsets, field positions, reset values and channel codes
// Assumes inclusion by bare name from design files under rtl/
`ifndef DIAG_MONITOR_DEFS_SVH
`define DIAG_MONITOR_DEFS_SVH

`define DMR_ADDR_HS_LIVE    8'h42
`define DMR_ADDR_THR_LIVE   8'h43
`define DMR_ADDR_UPPER      8'h4E
`define DMR_ADDR_LOWER      8'h4F
`define DMR_ADDR_FILT       8'h54
`define DMR_ADDR_CTRL       8'h55
`define DMR_ADDR_CH1P_HIGH  8'h62
`define DMR_ADDR_CH1P_LOW   8'h63

`define DMR_UPPER_RST       8'hBA
`define DMR_LOWER_RST       8'h4B
`define DMR_FILT_RST        8'h48
`define DMR_CTRL_RST        8'h00
`define DMR_RDATA_RST       8'h00
`define DMR_RESULT_RST      12'h000

`define DMR_FILT_RW_MASK    8'h7F
`define DMR_HS_INSERT_BIT   3
`define DMR_HS_REMOVE_BIT   2
`define DMR_HS_HOOK_BIT     1
`define DMR_THR_UP_BIT      7
`define DMR_THR_LOW_BIT     6
`define DMR_ASUP_FILT_MSB   6
`define DMR_ASUP_FILT_LSB   5
`define DMR_BSUP_FILT_MSB   3
`define DMR_BSUP_FILT_LSB   2
`define DMR_OVRD_BIT        1
`define DMR_FREEZE_BIT      0

`define DMR_CH1P_ID         4'h6
`define DMR_AUX_ID          4'hD
`define DMR_THR_SHIFT       4

`endif

// *** rtl/diag_monitor_live_status_regs.sv ***
// Diagnostic live status and monitor configuration register slice
// Assumes register port and event inputs are synchronous to i_mclk
//
// Overview of operation
// - 0x42 bit 3 shows live headset insertion
// - 0x42 bit 2 shows live headset removal
// - Hook-button flag placed at 0x42 bit 1
// - 0x43 bit 7 shows aux above upper
// - 0x43 bit 6 shows aux below lower
// - Upper threshold code at 0x4E, reset 0xBA
// - Lower threshold code at 0x4F, reset 0x4B
// - Threshold code shifted left four for comparison
// - 0x54 bits 6-5 select analog-supply filter
// - 0x54 bits 3-2 select battery-supply filter
// - 0x55 bit 1 enables battery/temperature override
// - 0x55 bit 0 freezes channel-1 positive data updates
// - 0x62 returns channel-1 positive high byte
// - 0x63 returns channel-1 positive low part
// - Low part: result nibble high, ID 0110b
`timescale 1ns/100ps
`include "diag_monitor_defs.svh"

module diag_monitor_live_status_regs (
  input  wire logic                          i_mclk,
  input  wire logic                          i_rstn,
  input  wire diag_monitor_pkg::reg_req_t    i_reg,
  input  wire diag_monitor_pkg::mon_sample_t i_sample,
  input  wire logic                          i_hs_insert,
  input  wire logic                          i_hs_remove,
  input  wire logic                          i_hs_hook,
  output logic [7:0]                         o_reg_rdata,
  output logic [1:0]                         o_analog_supply_filter_select,
  output logic [1:0]                         o_battery_supply_filter_select,
  output logic                               o_battery_temp_data_override,
  output logic                               o_monitor_data_freeze
);

  diag_monitor_pkg::main_state_t st_r;
  diag_monitor_pkg::main_state_t st_nxt;

  // All checks below run on i_mclk and rest while reset is low
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  logic [11:0] aux_result;
  logic [11:0] ch1p_result;
  logic [7:0]  ch1p_low_part;
  logic        aux_above;
  logic        aux_below;
  logic        freeze;

  assign freeze = st_r.ctrl[`DMR_FREEZE_BIT];

  // The comparator watches the aux channel live, so hold never applies here
  monitor_result_slot #(
    .CHAN_ID (`DMR_AUX_ID)
  ) u_aux_slot (
    .i_mclk     (i_mclk),
    .i_rstn     (i_rstn),
    .i_sample   (i_sample),
    .i_freeze   (1'b0),
    .o_result   (aux_result),
    .o_low_part ()
  );

  monitor_result_slot #(
    .CHAN_ID (`DMR_CH1P_ID)
  ) u_ch1p_slot (
    .i_mclk     (i_mclk),
    .i_rstn     (i_rstn),
    .i_sample   (i_sample),
    .i_freeze   (freeze),
    .o_result   (ch1p_result),
    .o_low_part (ch1p_low_part)
  );

  threshold_compare u_aux_cmp (
    .i_result     (aux_result),
    .i_upper_code (st_r.upper),
    .i_lower_code (st_r.lower),
    .o_above      (aux_above),
    .o_below      (aux_below)
  );

  always_comb begin
    st_nxt = st_r;

    // Live headset flags track their sources
    st_nxt.hs_live = {i_hs_insert, i_hs_remove, i_hs_hook};

    if (i_reg.wr) begin
      if (i_reg.addr == `DMR_ADDR_UPPER) begin
        st_nxt.upper = i_reg.wdata;
      end else if (i_reg.addr == `DMR_ADDR_LOWER) begin
        st_nxt.lower = i_reg.wdata;
      end else if (i_reg.addr == `DMR_ADDR_FILT) begin
        // Bit 7 is read-only zero; other reserved bits store as written
        st_nxt.filt = i_reg.wdata & `DMR_FILT_RW_MASK;
      end else if (i_reg.addr == `DMR_ADDR_CTRL) begin
        st_nxt.ctrl = i_reg.wdata;
      end
    end

    if (i_reg.rd) begin
      if (i_reg.addr == `DMR_ADDR_HS_LIVE) begin
        st_nxt.rdata = 8'h00;
        st_nxt.rdata[`DMR_HS_INSERT_BIT] = st_r.hs_live[2];
        st_nxt.rdata[`DMR_HS_REMOVE_BIT] = st_r.hs_live[1];
        st_nxt.rdata[`DMR_HS_HOOK_BIT]   = st_r.hs_live[0];
      end else if (i_reg.addr == `DMR_ADDR_THR_LIVE) begin
        st_nxt.rdata = 8'h00;
        st_nxt.rdata[`DMR_THR_UP_BIT]  = aux_above;
        st_nxt.rdata[`DMR_THR_LOW_BIT] = aux_below;
      end else if (i_reg.addr == `DMR_ADDR_UPPER) begin
        st_nxt.rdata = st_r.upper;
      end else if (i_reg.addr == `DMR_ADDR_LOWER) begin
        st_nxt.rdata = st_r.lower;
      end else if (i_reg.addr == `DMR_ADDR_FILT) begin
        st_nxt.rdata = st_r.filt;
      end else if (i_reg.addr == `DMR_ADDR_CTRL) begin
        st_nxt.rdata = st_r.ctrl;
      end else if (i_reg.addr == `DMR_ADDR_CH1P_HIGH) begin
        st_nxt.rdata = ch1p_result[11:4];
      end else if (i_reg.addr == `DMR_ADDR_CH1P_LOW) begin
        st_nxt.rdata = ch1p_low_part;
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= '{upper:   `DMR_UPPER_RST,
                lower:   `DMR_LOWER_RST,
                filt:    `DMR_FILT_RST,
                ctrl:    `DMR_CTRL_RST,
                hs_live: 3'h0,
                rdata:   `DMR_RDATA_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_reg_rdata = st_r.rdata;
  assign o_analog_supply_filter_select =
    st_r.filt[`DMR_ASUP_FILT_MSB:`DMR_ASUP_FILT_LSB];
  assign o_battery_supply_filter_select =
    st_r.filt[`DMR_BSUP_FILT_MSB:`DMR_BSUP_FILT_LSB];
  assign o_battery_temp_data_override = st_r.ctrl[`DMR_OVRD_BIT];
  assign o_monitor_data_freeze        = freeze;

  // Checks of register and monitor behaviour

  logic rd_hs;
  logic rd_thr;
  logic ch1p_take;

  assign rd_hs     = i_reg.rd && (i_reg.addr == `DMR_ADDR_HS_LIVE);
  assign rd_thr    = i_reg.rd && (i_reg.addr == `DMR_ADDR_THR_LIVE);
  assign ch1p_take = i_sample.valid && (i_sample.chan == `DMR_CH1P_ID);

  logic rd_filt;
  logic rd_ctrl;
  logic rd_high;
  logic rd_low;
  logic aux_take;

  assign rd_filt   = i_reg.rd && (i_reg.addr == `DMR_ADDR_FILT);
  assign rd_ctrl   = i_reg.rd && (i_reg.addr == `DMR_ADDR_CTRL);
  assign rd_high   = i_reg.rd && (i_reg.addr == `DMR_ADDR_CH1P_HIGH);
  assign rd_low    = i_reg.rd && (i_reg.addr == `DMR_ADDR_CH1P_LOW);
  assign aux_take  = i_sample.valid && (i_sample.chan == `DMR_AUX_ID);

  property p_hs_insert;
    rd_hs |=> (o_reg_rdata[3] == $past(i_hs_insert, 2));
  endproperty
  a_hs_insert: assert property (p_hs_insert)
    else $error("insert flag readback wrong");

  property p_hs_remove_hook;
    rd_hs |=> (o_reg_rdata[2] == $past(i_hs_remove, 2))
          && (o_reg_rdata[1] == $past(i_hs_hook, 2))
          && (o_reg_rdata[7:4] == 4'h0);
  endproperty
  a_hs_remove_hook: assert property (p_hs_remove_hook)
    else $error("remove or hook flag readback wrong");

  property p_thr_upper;
    rd_thr |=> (o_reg_rdata[7] == ($past(aux_result) > {$past(st_r.upper), 4'h0}));
  endproperty
  a_thr_upper: assert property (p_thr_upper)
    else $error("upper threshold flag wrong");

  property p_thr_lower;
    rd_thr |=> (o_reg_rdata[6] == ($past(aux_result) < {$past(st_r.lower), 4'h0}))
           && (o_reg_rdata[5:0] == 6'h00);
  endproperty
  a_thr_lower: assert property (p_thr_lower)
    else $error("lower threshold flag wrong");

  sequence s_wr_upper;
    i_reg.wr && !i_reg.rd && (i_reg.addr == `DMR_ADDR_UPPER);
  endsequence

  sequence s_rd_upper;
    i_reg.rd && !i_reg.wr && (i_reg.addr == `DMR_ADDR_UPPER);
  endsequence

  property p_upper_rw;
    s_wr_upper ##1 s_rd_upper |=> (o_reg_rdata == $past(i_reg.wdata, 2));
  endproperty
  a_upper_rw: assert property (p_upper_rw)
    else $error("upper threshold readback wrong");

  property p_filt_write;
    (i_reg.wr && (i_reg.addr == `DMR_ADDR_FILT)) |=>
      (o_analog_supply_filter_select  == $past(i_reg.wdata[6:5])) &&
      (o_battery_supply_filter_select == $past(i_reg.wdata[3:2]));
  endproperty
  a_filt_write: assert property (p_filt_write)
    else $error("filter select not taken");

  property p_ctrl_write;
    (i_reg.wr && (i_reg.addr == `DMR_ADDR_CTRL)) |=>
      (o_battery_temp_data_override == $past(i_reg.wdata[1])) &&
      (o_monitor_data_freeze == $past(i_reg.wdata[0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control bits not taken");

  property p_freeze_hold;
    o_monitor_data_freeze |=> $stable(ch1p_result);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold)
    else $error("monitor data moved while frozen");

  property p_ch1p_update;
    (ch1p_take && !o_monitor_data_freeze) |=>
      (ch1p_low_part == {$past(i_sample.data[3:0]), 4'h6}) ##0
      (ch1p_result[11:4] == $past(i_sample.data[11:4]));
  endproperty
  a_ch1p_update: assert property (p_ch1p_update)
    else $error("channel-1 positive data not updated");

  sequence s_wr_lower;
    i_reg.wr && !i_reg.rd && (i_reg.addr == `DMR_ADDR_LOWER);
  endsequence

  sequence s_rd_lower;
    i_reg.rd && !i_reg.wr && (i_reg.addr == `DMR_ADDR_LOWER);
  endsequence

  property p_lower_rw;
    s_wr_lower ##1 s_rd_lower |=> (o_reg_rdata == $past(i_reg.wdata, 2));
  endproperty
  a_lower_rw: assert property (p_lower_rw)
    else $error("lower threshold readback wrong");

  property p_hs_reserved;
    rd_hs |=> (o_reg_rdata[0] == 1'b0);
  endproperty
  a_hs_reserved: assert property (p_hs_reserved)
    else $error("reserved headset status bit not zero");

  property p_filt_read;
    rd_filt |=> (o_reg_rdata[7] == 1'b0) &&
                (o_reg_rdata[6:5] == $past(o_analog_supply_filter_select)) &&
                (o_reg_rdata[3:2] == $past(o_battery_supply_filter_select));
  endproperty
  a_filt_read: assert property (p_filt_read)
    else $error("filter select readback wrong");

  property p_filt_hold;
    !(i_reg.wr && (i_reg.addr == `DMR_ADDR_FILT)) |=>
      $stable(o_analog_supply_filter_select) && $stable(o_battery_supply_filter_select);
  endproperty
  a_filt_hold: assert property (p_filt_hold)
    else $error("filter select changed without a write");

  property p_ctrl_read;
    rd_ctrl |=> (o_reg_rdata[1:0] ==
                 {$past(o_battery_temp_data_override), $past(o_monitor_data_freeze)});
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control readback wrong");

  property p_ctrl_hold;
    !(i_reg.wr && (i_reg.addr == `DMR_ADDR_CTRL)) |=>
      $stable(o_battery_temp_data_override) && $stable(o_monitor_data_freeze);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control bits changed without a write");

  property p_high_read;
    rd_high |=> (o_reg_rdata == $past(ch1p_result[11:4]));
  endproperty
  a_high_read: assert property (p_high_read)
    else $error("channel-1 positive high byte readback wrong");

  property p_low_read;
    rd_low |=> (o_reg_rdata[3:0] == `DMR_CH1P_ID) &&
               (o_reg_rdata[7:4] == $past(ch1p_result[3:0]));
  endproperty
  a_low_read: assert property (p_low_read)
    else $error("channel-1 positive low part readback wrong");

  property p_freeze_pair;
    o_monitor_data_freeze |=> $stable(ch1p_low_part);
  endproperty
  a_freeze_pair: assert property (p_freeze_pair)
    else $error("low part moved while frozen");

  property p_aux_update;
    aux_take |=> (aux_result == $past(i_sample.data));
  endproperty
  a_aux_update: assert property (p_aux_update)
    else $error("aux result not taken");

  property p_rdata_hold;
    !i_reg.rd |=> $stable(o_reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  sequence s_aux_over;
    aux_take && !i_reg.wr && (i_sample.data > {st_r.upper, 4'h0});
  endsequence

  sequence s_aux_under;
    aux_take && !i_reg.wr && (i_sample.data < {st_r.lower, 4'h0});
  endsequence

  sequence s_quiet;
    !aux_take && !i_reg.wr;
  endsequence

  property p_over_flag;
    s_aux_over ##1 s_quiet ##1 rd_thr |=> o_reg_rdata[`DMR_THR_UP_BIT];
  endproperty
  a_over_flag: assert property (p_over_flag)
    else $error("upper flag missing after high sample");

  property p_under_flag;
    s_aux_under ##1 s_quiet ##1 rd_thr |=> o_reg_rdata[`DMR_THR_LOW_BIT];
  endproperty
  a_under_flag: assert property (p_under_flag)
    else $error("lower flag missing after low sample");

endmodule

// *** rtl/diag_monitor_pkg.sv ***
// Types shared by the diagnostic monitor register slice
// Assumes nothing beyond a SystemVerilog compiler
package diag_monitor_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  chan;
    logic [11:0] data;
  } mon_sample_t;

  typedef struct packed {
    logic [11:0] result;
  } slot_state_t;

  typedef struct packed {
    logic [7:0]  upper;
    logic [7:0]  lower;
    logic [7:0]  filt;
    logic [7:0]  ctrl;
    logic [2:0]  hs_live;
    logic [7:0]  rdata;
  } main_state_t;

endpackage

// *** rtl/monitor_result_slot.sv ***
// One monitor conversion slot: keeps the latest 12-bit result of one channel
// Assumes samples arrive as one-cycle valid strobes on i_mclk
`timescale 1ns/100ps
`include "diag_monitor_defs.svh"

module monitor_result_slot #(
  parameter logic [3:0] CHAN_ID = `DMR_CH1P_ID
) (
  input  wire logic                         i_mclk,
  input  wire logic                         i_rstn,
  input  wire diag_monitor_pkg::mon_sample_t i_sample,
  input  wire logic                         i_freeze,
  output logic [11:0]                       o_result,
  output logic [7:0]                        o_low_part
);

  diag_monitor_pkg::slot_state_t st_r;
  diag_monitor_pkg::slot_state_t st_nxt;

  // High byte and low nibble move together, never while frozen
  always_comb begin
    st_nxt = st_r;
    if (i_sample.valid && (i_sample.chan == CHAN_ID) && !i_freeze) begin
      st_nxt.result = i_sample.data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= '{result: `DMR_RESULT_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_result   = st_r.result;
  assign o_low_part = {st_r.result[3:0], CHAN_ID};

endmodule

// *** rtl/threshold_compare.sv ***
// Window comparator of a 12-bit result against two 8-bit threshold codes
// Assumes codes sit on the top eight bits of the 12-bit scale
`timescale 1ns/100ps
`include "diag_monitor_defs.svh"

module threshold_compare (
  input  wire logic [11:0] i_result,
  input  wire logic [7:0]  i_upper_code,
  input  wire logic [7:0]  i_lower_code,
  output logic             o_above,
  output logic             o_below
);

  logic [11:0] upper_scaled;
  logic [11:0] lower_scaled;

  // Code N stands for 16*N on the monitor scale
  assign upper_scaled = {i_upper_code, 4'h0};
  assign lower_scaled = {i_lower_code, 4'h0};
  assign o_above      = (i_result > upper_scaled);
  assign o_below      = (i_result < lower_scaled);

endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the diagnostic live status register slice
// Assumes rtl/ sources compiled first and the defs header on the include path
`timescale 1ns/100ps
`include "diag_monitor_defs.svh"

module testbench;
  logic                          i_mclk;
  logic                          i_rstn;
  diag_monitor_pkg::reg_req_t    reg_in;
  diag_monitor_pkg::mon_sample_t smp;
  logic                          hs_ins;
  logic                          hs_rem;
  logic                          hs_hook;
  logic [7:0]                    rdata;
  logic [1:0]                    asup_sel;
  logic [1:0]                    bsup_sel;
  logic                          ovrd;
  logic                          frz;
  int                            failures;
  int                            samples_checked;
  int                            up, lo, filt, ctrl, ch1, aux;
  logic [7:0]                    lfsr;
  logic [7:0]                    addr_list [10];

  diag_monitor_live_status_regs i_dut (
    .i_mclk                         (i_mclk),
    .i_rstn                         (i_rstn),
    .i_reg                          (reg_in),
    .i_sample                       (smp),
    .i_hs_insert                    (hs_ins),
    .i_hs_remove                    (hs_rem),
    .i_hs_hook                      (hs_hook),
    .o_reg_rdata                    (rdata),
    .o_analog_supply_filter_select  (asup_sel),
    .o_battery_supply_filter_select (bsup_sel),
    .o_battery_temp_data_override   (ovrd),
    .o_monitor_data_freeze          (frz)
  );

  always #4 i_mclk = ~i_mclk;

  function automatic logic [7:0] next_rand(input logic [7:0] s);
    next_rand = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      `DMR_ADDR_HS_LIVE:   exp_rd = {4'h0, hs_ins, hs_rem, hs_hook, 1'b0};
      `DMR_ADDR_THR_LIVE:  exp_rd = {aux > up * 16, aux < lo * 16, 6'h00};
      `DMR_ADDR_UPPER:     exp_rd = 8'(up);
      `DMR_ADDR_LOWER:     exp_rd = 8'(lo);
      `DMR_ADDR_FILT:      exp_rd = 8'(filt);
      `DMR_ADDR_CTRL:      exp_rd = 8'(ctrl);
      `DMR_ADDR_CH1P_HIGH: exp_rd = 8'(ch1 / 16);
      `DMR_ADDR_CH1P_LOW:  exp_rd = 8'((ch1 % 16) * 16 + 6);
      default:             exp_rd = 8'h00;
    endcase
  endfunction

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a);
    @(negedge i_mclk);
    reg_in.rd   = 1'b1;
    reg_in.addr = a;
    @(negedge i_mclk);
    reg_in.rd = 1'b0;
    cmp(rdata, exp_rd(a), $sformatf("read %h", a));
  endtask

  task automatic cfg_chk();
    cmp({2'h0, asup_sel, bsup_sel, ovrd, frz},
        8'((filt / 32 % 4) * 16 + (filt / 4 % 4) * 4 + ctrl % 4), "config outputs");
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    reg_in.wr    = 1'b1;
    reg_in.addr  = a;
    reg_in.wdata = d;
    @(negedge i_mclk);
    reg_in.wr = 1'b0;
    reg_in.rd = 1'b1;
    case (a)
      `DMR_ADDR_UPPER: up = d;
      `DMR_ADDR_LOWER: lo = d;
      `DMR_ADDR_FILT:  filt = d & `DMR_FILT_RW_MASK;
      `DMR_ADDR_CTRL:  ctrl = d;
      default: ;
    endcase
    cfg_chk();
    @(negedge i_mclk);
    reg_in.rd = 1'b0;
    cmp(rdata, exp_rd(a), $sformatf("readback %h", a));
  endtask

  task automatic send(input logic [3:0] ch, input logic [11:0] d);
    @(negedge i_mclk);
    smp = '{valid: 1'b1, chan: ch, data: d};
    @(negedge i_mclk);
    smp.valid = 1'b0;
    if (ch == `DMR_CH1P_ID && ctrl % 2 == 0) ch1 = d;
    if (ch == `DMR_AUX_ID) aux = d;
  endtask

  task automatic model_reset();
    up   = `DMR_UPPER_RST;
    lo   = `DMR_LOWER_RST;
    filt = `DMR_FILT_RST;
    ctrl = `DMR_CTRL_RST;
    ch1  = 0;
    aux  = 0;
  endtask

  task automatic reset_chk(input string name);
    @(negedge i_mclk);
    i_rstn  = 1'b0;
    hs_ins  = 1'b0;
    hs_rem  = 1'b0;
    hs_hook = 1'b0;
    model_reset();
    repeat (5) @(negedge i_mclk);
    i_rstn = 1'b1;
    cmp(rdata, `DMR_RDATA_RST, "read data after reset");
    cfg_chk();
    foreach (addr_list[k]) rd_chk(addr_list[k]);
    $display("test %s finished, %0d mismatches so far", name, failures);
  endtask

  task automatic end_of_test();
    $display("checks made %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    i_mclk          = 1'b0;
    i_rstn          = 1'b0;
    hs_ins          = 1'b0;
    hs_rem          = 1'b0;
    hs_hook         = 1'b0;
    reg_in          = '0;
    smp             = '0;
    failures        = 0;
    samples_checked = 0;
    lfsr            = 8'h2B;
    addr_list = '{`DMR_ADDR_HS_LIVE, `DMR_ADDR_THR_LIVE, `DMR_ADDR_UPPER, `DMR_ADDR_LOWER,
                  `DMR_ADDR_FILT, `DMR_ADDR_CTRL, `DMR_ADDR_CH1P_HIGH, `DMR_ADDR_CH1P_LOW,
                  8'h44, 8'h00};
    reset_chk("reset values");
    for (int v = 0; v < 4; v++) begin
      wr_reg(`DMR_ADDR_FILT, 8'(v * 32 + (3 - v) * 4));
    end
    wr_reg(`DMR_ADDR_CTRL, 8'h02);
    wr_reg(`DMR_ADDR_HS_LIVE, 8'h0C);
    wr_reg(`DMR_ADDR_CH1P_HIGH, 8'h55);
    $display("test config finished, %0d mismatches so far", failures);
    repeat (4) begin
      lfsr = next_rand(lfsr);
      wr_reg(`DMR_ADDR_UPPER, lfsr);
      lfsr = next_rand(lfsr);
      wr_reg(`DMR_ADDR_LOWER, lfsr);
      for (int d = -1; d < 2; d++) begin
        send(`DMR_AUX_ID, 12'(up * 16 + d));
        rd_chk(`DMR_ADDR_THR_LIVE);
        send(`DMR_AUX_ID, 12'(lo * 16 + d));
        rd_chk(`DMR_ADDR_THR_LIVE);
      end
    end
    $display("test thresholds finished, %0d mismatches so far", failures);
    for (int m = 0; m < 8; m++) begin
      @(negedge i_mclk);
      {hs_ins, hs_rem, hs_hook} = 3'(m);
      rd_chk(`DMR_ADDR_HS_LIVE);
    end
    $display("test headset finished, %0d mismatches so far", failures);
    lfsr = next_rand(lfsr);
    send(`DMR_CH1P_ID, {lfsr, 4'hA});
    rd_chk(`DMR_ADDR_CH1P_HIGH);
    rd_chk(`DMR_ADDR_CH1P_LOW);
    wr_reg(`DMR_ADDR_CTRL, 8'h01);
    send(`DMR_CH1P_ID, ~{lfsr, 4'hA});
    send(`DMR_AUX_ID, 12'h000);
    rd_chk(`DMR_ADDR_CH1P_HIGH);
    rd_chk(`DMR_ADDR_CH1P_LOW);
    rd_chk(`DMR_ADDR_THR_LIVE);
    wr_reg(`DMR_ADDR_CTRL, 8'h00);
    send(`DMR_CH1P_ID, 12'h5A3);
    rd_chk(`DMR_ADDR_CH1P_HIGH);
    rd_chk(`DMR_ADDR_CH1P_LOW);
    $display("test freeze finished, %0d mismatches so far", failures);
    hs_ins = 1'b1;
    reset_chk("second reset");
    end_of_test();
  end

  initial begin
    #(8 * 20000);
    failures++;
    $display("CHECK FAILED at %0t: run did not finish in time", $time);
    end_of_test();
  end
endmodule
